// ### verilog/swwd_pkg.sv
// shared constants and types of the sleep, wake and watchdog block
package swwd_pkg;
    // clock rate and times as printed
    localparam int unsigned CLK_MHZ = 40;
    localparam int unsigned TPOR_US = 24000;
    localparam int unsigned TWDT_RC_US = 8000;
    // derived cycle counts
    localparam int unsigned POR_CYCLES = TPOR_US * CLK_MHZ;
    localparam int unsigned WDT_RC_CYCLES = TWDT_RC_US * CLK_MHZ;
    localparam int unsigned OSCILLATOR_INPUT_WAIT_CYCLES = 18;
    localparam int unsigned WDT_SYS_CYCLES = 32512;
    localparam int unsigned CNT_W = 20;
    // register offsets
    localparam logic [7:0] ADDR_P2DIR = 8'hf6;
    localparam logic [7:0] ADDR_IPRIO = 8'hf9;
    localparam logic [7:0] ADDR_IPEND = 8'hfa;
    localparam logic [7:0] ADDR_IMASK = 8'hfb;
    localparam logic [7:0] ADDR_SCRATCH = 8'hfe;
    localparam logic [7:0] ADDR_SPL = 8'hff;
    // reset values and fields
    localparam logic [7:0] P2DIR_RESET = 8'hff;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam logic [5:0] PEND_RESET = 6'h00;
    localparam logic [7:0] IMASK_RESET = 8'h00;
    localparam logic [7:0] IPRIO_RESET = 8'h00;
    localparam int unsigned IMASK_GLOBAL_BIT = 7;
    localparam int unsigned IPRIO_ORDER_BIT = 0;
    localparam int unsigned NUM_REQ = 6;
    // request bit positions
    localparam int unsigned REQ_PIN_B_FALL = 0;
    localparam int unsigned REQ_PIN_C_FALL = 1;
    localparam int unsigned REQ_PIN_A_FALL = 2;
    localparam int unsigned REQ_PIN_B_RISE = 3;
    localparam int unsigned REQ_TIMER_ZERO = 4;
    localparam int unsigned REQ_TIMER_ONE = 5;
    // opcodes
    localparam logic [7:0] OP_WDT_ARM = 8'h5f;
    localparam logic [7:0] OP_WDT_HALT_KEEP = 8'h4f;
    localparam logic [7:0] OP_HALT = 8'h70;
    localparam logic [7:0] OP_STOP = 8'h60;
    // restart address after reset or stop release
    localparam logic [15:0] RESTART_ADDR = 16'h000c;
    localparam logic [15:0] VECTOR_BASE = 16'h0000;

    // pins from outside, all asynchronous
    typedef struct packed {
        logic stop_wake_pin;
        logic input_pin_c;
        logic input_pin_b;
        logic input_pin_a;
    } swwd_pins_t;

    // operating states
    typedef enum logic [2:0] {
        ST_POR_WAIT,
        ST_OSCILLATOR_INPUT_WAIT,
        ST_RUN,
        ST_HALT,
        ST_STOP
    } swwd_state_t;
endpackage

// ### verilog/swwd_sync.sv
// two-flop synchroniser for asynchronous pin levels
`timescale 1ns/1ps
`default_nettype none
module swwd_sync #(
    parameter int unsigned W = 4
) (
    input wire logic i_mclk,
    input wire logic i_rstn,
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync
);
    logic [W-1:0] meta;

    // first stage feeds only the second
    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            meta <= '1;
            o_sync <= '1;
        end else begin
            meta <= i_async;
            o_sync <= meta;
        end
    end
endmodule // swwd_sync
`default_nettype wire

// ### verilog/swwd_sleep_wake.sv
// halt, stop, interrupt request and watchdog control of the controller
//
// Summary of operation
// RULE1: pending bits set on requests even when masked, so software may poll.
// RULE2: six requests vector through byte pairs 0,1 up to 10,11.
// RULE3: falling edges of pins a,b,c and rising edge of b; counters raise two.
// RULE4: halt gates the cpu clock, oscillator keeps running.
// RULE5: counters and pin edges keep raising requests during halt.
// RULE6: halt is left only by an enabled request; code resumes after halt. Here a watchdog expiry in halt also leaves it.
// RULE7: stop halts cpu clock and oscillator.
// RULE8: low wake pin releases stop; full reset releases it too.
// RULE9: after stop release execution restarts at 000c.
// RULE10: wake release keeps port direction register contents.
// RULE11: software puts a no-operation before halt or stop.
// RULE12: software sets direction top bit, no-operation, then stop.
// RULE13: first arm opcode enables watchdog; nothing stops it afterwards.
// RULE14: each later arm opcode clears counter; expiry resets the device.
// RULE15: arm opcode sets zero flag, clears sign and overflow.
// RULE16: watchdog reset equals power-on: wait then 18 oscillator cycles.
// RULE17: without permanent option no run in stop; disabled after reset until armed.
// RULE18: halt-keep opcode runs watchdog in halt without clearing; needs arming first.
// RULE19: permanent option runs from reset in all states, not stop on system clock.
// RULE20: system-clock option counts core cycles, expires after 32512, not in stop.
// RULE21: system clock is half the oscillator input.
// RULE22: scratch register and stack pointer low clear on stop release and reset.
// RULE23: oscillator-timed watchdog length is a build parameter.
// RULE24: pin edges sampled on oscillator clock so halt does not hide them.
//
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module swwd_sleep_wake #(
    parameter int unsigned P_POR_CYCLES = swwd_pkg::POR_CYCLES,
    parameter int unsigned P_WDT_RC_CYCLES = swwd_pkg::WDT_RC_CYCLES,
    parameter bit P_PERMANENT = 1'b0,
    parameter bit P_SYSCLK = 1'b0
) (
    input wire logic i_mclk,
    input wire logic i_rstn,
    input wire swwd_pkg::swwd_pins_t i_pins,
    input wire logic i_counter_zero,
    input wire logic i_counter_one,
    input wire logic i_exec,
    input wire logic [7:0] i_opcode,
    input wire logic i_int_ack,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    output logic o_core_rst_n,
    output logic o_cpu_clk_en,
    output logic o_sys_tick,
    output logic o_osc_run,
    output logic o_pc_load,
    output logic [15:0] o_pc_value,
    output logic o_irq_req,
    output logic [15:0] o_irq_vector,
    output logic o_flag_wdt,
    output logic [7:0] o_port_two_direction,
    output logic o_wdt_armed
);
    localparam int unsigned CW = swwd_pkg::CNT_W;
    localparam logic [CW-1:0] POR_LAST = CW'(P_POR_CYCLES - 1);
    localparam logic [CW-1:0] OSCILLATOR_INPUT_LAST = CW'(swwd_pkg::OSCILLATOR_INPUT_WAIT_CYCLES - 1);
    localparam logic [CW-1:0] WDT_LAST =
        CW'((P_SYSCLK ? swwd_pkg::WDT_SYS_CYCLES : P_WDT_RC_CYCLES) - 1);

    // opcode decode, used for every opcode
    function automatic logic swwd_is_op(input logic ex, input logic [7:0] op,
                                        input logic [7:0] want);
        swwd_is_op = ex && (op == want);
    endfunction

    // pick the winning request: ascending index, or descending if asked
    function automatic logic [2:0] swwd_pick(input logic [5:0] act, input logic desc);
        logic [2:0] idx;
        idx = 3'h0;
        for (int i = 0; i < swwd_pkg::NUM_REQ; i++) begin
            if (desc && act[i]) begin
                idx = 3'(i);
            end
        end
        if (!desc) begin
            for (int i = swwd_pkg::NUM_REQ - 1; i >= 0; i--) begin
                if (act[i]) begin
                    idx = 3'(i);
                end
            end
        end
        swwd_pick = idx;
    endfunction

    swwd_pkg::swwd_pins_t pins_s;
    swwd_pkg::swwd_pins_t pins_d;
    swwd_pkg::swwd_state_t state;
    logic [CW-1:0] seq_cnt;
    logic [CW-1:0] wd_cnt;
    logic half;
    logic armed;
    logic halt_keep;
    logic wd_expire;
    logic wd_run;
    logic wd_step;
    logic [5:0] pending;
    logic [5:0] req_set;
    logic [5:0] active;
    logic [7:0] imask;
    logic [7:0] iprio;
    logic [7:0] scratch;
    logic [7:0] stack_pointer_low;
    logic [2:0] win;
    logic in_run;
    logic op_arm;
    logic op_keep;
    logic op_halt;
    logic op_stop;
    logic wake_rel;
    logic seq_done;

    // RULE24 synced pins
    swwd_sync #(.W(4)) u_sync (
        .i_mclk(i_mclk),
        .i_rstn(i_rstn),
        .i_async(i_pins),
        .o_sync(pins_s)
    );

    // previous synced levels for edge detection
    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            pins_d <= '1;
        end else begin
            pins_d <= pins_s;
        end
    end

    assign in_run = (state == swwd_pkg::ST_RUN);
    assign op_arm = in_run && swwd_is_op(i_exec, i_opcode, swwd_pkg::OP_WDT_ARM);
    assign op_keep = in_run && swwd_is_op(i_exec, i_opcode, swwd_pkg::OP_WDT_HALT_KEEP);
    assign op_halt = in_run && swwd_is_op(i_exec, i_opcode, swwd_pkg::OP_HALT);
    assign op_stop = in_run && swwd_is_op(i_exec, i_opcode, swwd_pkg::OP_STOP);
    // RULE8 wake level in stop
    assign wake_rel = (state == swwd_pkg::ST_STOP) && !pins_s.stop_wake_pin;
    assign seq_done = (state == swwd_pkg::ST_OSCILLATOR_INPUT_WAIT) && (seq_cnt == OSCILLATOR_INPUT_LAST);

    // RULE3 edge and counter requests; RULE5 live in halt, oscillator off in stop
    always_comb begin
        req_set = '0;
        if (state != swwd_pkg::ST_STOP) begin
            req_set[swwd_pkg::REQ_PIN_B_FALL] = pins_d.input_pin_b && !pins_s.input_pin_b;
            req_set[swwd_pkg::REQ_PIN_C_FALL] = pins_d.input_pin_c && !pins_s.input_pin_c;
            req_set[swwd_pkg::REQ_PIN_A_FALL] = pins_d.input_pin_a && !pins_s.input_pin_a;
            req_set[swwd_pkg::REQ_PIN_B_RISE] = !pins_d.input_pin_b && pins_s.input_pin_b;
            req_set[swwd_pkg::REQ_TIMER_ZERO] = i_counter_zero;
            req_set[swwd_pkg::REQ_TIMER_ONE] = i_counter_one;
        end
    end

    assign active = pending & imask[5:0] & {6{imask[swwd_pkg::IMASK_GLOBAL_BIT]}};
    assign win = swwd_pick(active, iprio[swwd_pkg::IPRIO_ORDER_BIT]);

    // RULE1 pending bits set regardless of mask; a set beats a clear
    always_ff @(posedge i_mclk) begin
        if (!i_rstn || !o_core_rst_n) begin
            pending <= swwd_pkg::PEND_RESET;
        end else begin
            pending <= ((i_wr && i_addr == swwd_pkg::ADDR_IPEND) ? i_wdata[5:0] :
                        (i_int_ack ? (pending & ~(6'h01 << win)) : pending)) | req_set;
        end
    end

    // mask and priority; a taken request drops the global enable
    always_ff @(posedge i_mclk) begin
        if (!i_rstn || !o_core_rst_n) begin
            imask <= swwd_pkg::IMASK_RESET;
            iprio <= swwd_pkg::IPRIO_RESET;
        end else begin
            if (i_wr && i_addr == swwd_pkg::ADDR_IMASK) begin
                imask <= i_wdata;
            end else if (i_int_ack) begin
                imask[swwd_pkg::IMASK_GLOBAL_BIT] <= 1'b0;
            end
            if (i_wr && i_addr == swwd_pkg::ADDR_IPRIO) begin
                iprio <= i_wdata;
            end
        end
    end

    // RULE10 direction register survives wake release, reset restores inputs
    always_ff @(posedge i_mclk) begin
        if (!i_rstn || !o_core_rst_n) begin
            o_port_two_direction <= swwd_pkg::P2DIR_RESET;
        end else if (i_wr && i_addr == swwd_pkg::ADDR_P2DIR) begin
            o_port_two_direction <= i_wdata;
        end
    end

    // RULE22 scratch and stack low cleared on reset and stop release
    always_ff @(posedge i_mclk) begin
        if (!i_rstn || !o_core_rst_n || wake_rel) begin
            scratch <= swwd_pkg::ZERO_BYTE;
            stack_pointer_low <= swwd_pkg::ZERO_BYTE;
        end else begin
            if (i_wr && i_addr == swwd_pkg::ADDR_SCRATCH) begin
                scratch <= i_wdata;
            end
            if (i_wr && i_addr == swwd_pkg::ADDR_SPL) begin
                stack_pointer_low <= i_wdata;
            end
        end
    end

    // read data one cycle after the strobe; write-only and unmapped read zero
    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            o_rdata <= swwd_pkg::ZERO_BYTE;
        end else if (i_rd) begin
            unique case (i_addr)
                swwd_pkg::ADDR_IPEND: o_rdata <= {2'h0, pending};
                swwd_pkg::ADDR_IMASK: o_rdata <= imask;
                swwd_pkg::ADDR_SCRATCH: o_rdata <= scratch;
                swwd_pkg::ADDR_SPL: o_rdata <= stack_pointer_low;
                default: o_rdata <= swwd_pkg::ZERO_BYTE;
            endcase
        end else begin
            o_rdata <= swwd_pkg::ZERO_BYTE;
        end
    end

    // operating state machine
    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            state <= swwd_pkg::ST_POR_WAIT;
            seq_cnt <= '0;
        end else if (wd_expire) begin
            // RULE14 expiry restarts the reset sequence
            state <= swwd_pkg::ST_POR_WAIT;
            seq_cnt <= '0;
        end else begin
            unique case (state)
                // RULE16 power-on wait then oscillator cycles
                swwd_pkg::ST_POR_WAIT: begin
                    seq_cnt <= (seq_cnt == POR_LAST) ? '0 : seq_cnt + 1'b1;
                    if (seq_cnt == POR_LAST) begin
                        state <= swwd_pkg::ST_OSCILLATOR_INPUT_WAIT;
                    end
                end
                swwd_pkg::ST_OSCILLATOR_INPUT_WAIT: begin
                    seq_cnt <= seq_done ? '0 : seq_cnt + 1'b1;
                    if (seq_done) begin
                        state <= swwd_pkg::ST_RUN;
                    end
                end
                // RULE4 halt and RULE7 stop entered from run only
                swwd_pkg::ST_RUN: begin
                    if (op_halt) begin
                        state <= swwd_pkg::ST_HALT;
                    end else if (op_stop) begin
                        state <= swwd_pkg::ST_STOP;
                    end
                end
                // RULE6 only an enabled request returns halt to run; watchdog expiry leaves halt through the reset sequence
                swwd_pkg::ST_HALT: begin
                    if (|active) begin
                        state <= swwd_pkg::ST_RUN;
                    end
                end
                // RULE8 low wake pin releases stop
                swwd_pkg::ST_STOP: begin
                    if (wake_rel) begin
                        state <= swwd_pkg::ST_RUN;
                    end
                end
            endcase
        end
    end

    // RULE21 system clock tick at half the oscillator rate
    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            half <= 1'b0;
            o_sys_tick <= 1'b0;
            o_cpu_clk_en <= 1'b0;
            o_osc_run <= 1'b1;
        end else begin
            half <= (state == swwd_pkg::ST_STOP) ? 1'b0 : ~half;
            o_sys_tick <= (state != swwd_pkg::ST_STOP) && !half;
            // RULE4 cpu clock gated outside run
            o_cpu_clk_en <= in_run && !op_halt && !op_stop && !half;
            // RULE7 oscillator off in stop
            o_osc_run <= !((state == swwd_pkg::ST_STOP && !wake_rel) || op_stop);
        end
    end

    // core reset and restart address
    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            o_core_rst_n <= 1'b0;
            o_pc_load <= 1'b0;
            o_pc_value <= swwd_pkg::RESTART_ADDR;
        end else begin
            o_core_rst_n <= !(wd_expire || state == swwd_pkg::ST_POR_WAIT ||
                              (state == swwd_pkg::ST_OSCILLATOR_INPUT_WAIT && !seq_done));
            // RULE9 both releases restart at the fixed address
            o_pc_load <= (seq_done || wake_rel) && !wd_expire;
            o_pc_value <= swwd_pkg::RESTART_ADDR;
        end
    end

    // RULE2 vector of the winning request is twice its index
    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            o_irq_req <= 1'b0;
            o_irq_vector <= swwd_pkg::VECTOR_BASE;
        end else begin
            o_irq_req <= |active && o_core_rst_n && !i_int_ack;
            o_irq_vector <= swwd_pkg::VECTOR_BASE + {12'h000, win, 1'b0};
        end
    end

    // RULE17 watchdog run conditions per state; RULE19 permanent option
    always_comb begin
        unique case (state)
            swwd_pkg::ST_RUN: wd_run = armed;
            // RULE18 halt only with keep or permanent
            swwd_pkg::ST_HALT: wd_run = armed && (halt_keep || P_PERMANENT);
            // RULE20 never in stop on the system clock
            swwd_pkg::ST_STOP: wd_run = armed && P_PERMANENT && !P_SYSCLK;
            default: wd_run = 1'b0;
        endcase
    end

    // RULE20 count core cycles or oscillator cycles; RULE23 length parameter
    assign wd_step = wd_run && (P_SYSCLK ? o_sys_tick : 1'b1);
    assign wd_expire = wd_step && (wd_cnt == WDT_LAST);

    // RULE13 arming is sticky; RULE14 refresh clears the counter
    always_ff @(posedge i_mclk) begin
        if (!i_rstn || wd_expire) begin
            armed <= P_PERMANENT;
            halt_keep <= 1'b0;
            wd_cnt <= '0;
        end else begin
            if (op_arm) begin
                armed <= 1'b1;
            end
            // RULE18 keep needs an armed watchdog
            if (op_keep && armed) begin
                halt_keep <= 1'b1;
            end
            if (op_arm) begin
                wd_cnt <= '0;
            end else if (wd_step) begin
                wd_cnt <= wd_cnt + 1'b1;
            end
        end
    end

    // RULE15 flag update pulse on the arm opcode
    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            o_flag_wdt <= 1'b0;
            o_wdt_armed <= P_PERMANENT;
        end else begin
            o_flag_wdt <= op_arm;
            o_wdt_armed <= armed;
        end
    end

    // checks
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rstn);

    pend_poll_a: assert property (req_set[swwd_pkg::REQ_TIMER_ZERO] // RULE1
        |=> pending[swwd_pkg::REQ_TIMER_ZERO]) else $error("request lost");
    pin_edge_a: assert property ($fell(pins_s.input_pin_b) && state != swwd_pkg::ST_STOP // RULE3
        |=> pending[swwd_pkg::REQ_PIN_B_FALL]) else $error("falling edge lost");
    vec_pair_a: assert property (o_irq_req |-> o_irq_vector[0] == 1'b0 // RULE2
        && o_irq_vector <= 16'h000a) else $error("vector out of table");
    halt_gate_a: assert property (state == swwd_pkg::ST_HALT |=> !o_cpu_clk_en // RULE4
        ) else $error("cpu clock in halt");
    halt_exit_a: assert property (state == swwd_pkg::ST_HALT && !(|active) && !wd_expire // RULE6
        |=> state == swwd_pkg::ST_HALT) else $error("halt left without request");
    stop_osc_a: assert property (state == swwd_pkg::ST_STOP && !wake_rel // RULE7
        |=> !o_osc_run) else $error("oscillator runs in stop");
    wake_pc_a: assert property (wake_rel && !wd_expire |=> o_pc_load // RULE9
        && o_pc_value == 16'h000c) else $error("no restart at wake");
    dir_keep_a: assert property (wake_rel && !(i_wr && i_addr == swwd_pkg::ADDR_P2DIR) // RULE10
        |=> $stable(o_port_two_direction)) else $error("direction lost at wake");
    wd_refresh_a: assert property (op_arm && !wd_expire |=> wd_cnt == '0 && armed // RULE14
        ) else $error("refresh did not clear");
    flag_pulse_a: assert property (op_arm |=> o_flag_wdt ##1 !o_flag_wdt || $past(op_arm) // RULE15
        ) else $error("flag pulse wrong");
    oscillator_input_len_a: assert property ($rose(state == swwd_pkg::ST_OSCILLATOR_INPUT_WAIT) // RULE16
        |-> !o_pc_load [*8] ##11 o_pc_load) else $error("oscillator wait length");
    half_rate_a: assert property (o_sys_tick |=> !o_sys_tick) else $error("tick too fast"); // RULE21
    scratch_clr_a: assert property (wake_rel |=> scratch == 8'h00 && stack_pointer_low == 8'h00 // RULE22
        ) else $error("scratch not cleared");

    cov_halt_wake_c: cover property (state == swwd_pkg::ST_HALT ##1 state == swwd_pkg::ST_RUN);
    cov_stop_wake_c: cover property (state == swwd_pkg::ST_STOP ##1 state == swwd_pkg::ST_RUN);
    cov_wd_expire_c: cover property (wd_expire);
    cov_ack_c: cover property (o_irq_req ##1 i_int_ack);
endmodule // swwd_sleep_wake
`default_nettype wire

// ### tb/swwd_pin_model.sv
// behavioural driver of the external interrupt and wake pins
`timescale 1ns/1ps
`default_nettype none
module swwd_pin_model (
    input wire logic i_mclk,
    output var swwd_pkg::swwd_pins_t o_pins
);
    // pins idle high until the bench asks for a change
    initial begin
        o_pins = '1;
    end
    task automatic drive(input logic [3:0] v);
        @(posedge i_mclk);
        o_pins <= swwd_pkg::swwd_pins_t'(v);
    endtask
endmodule // swwd_pin_model
`default_nettype wire

// ### tb/test_swwd_sleep_wake.sv
// self-checking bench of the sleep, wake and watchdog block
`timescale 1ns/1ps
`default_nettype none
module test_swwd_sleep_wake;
    localparam int POR = 20;
    logic i_mclk, i_rstn, i_counter_zero, i_counter_one, i_exec, i_int_ack, i_wr, i_rd;
    logic [7:0] i_opcode, i_addr, i_wdata, o_rdata, o_port_two_direction;
    logic [15:0] o_pc_value, o_irq_vector;
    logic o_core_rst_n, o_cpu_clk_en, o_osc_run, o_pc_load, o_irq_req, o_flag_wdt, o_wdt_armed;
    logic o_sys_tick;
    swwd_pkg::swwd_pins_t i_pins;
    int bad_count = 0;
    int n_checks = 0;
    `define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin bad_count++; \
        $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
    // device under test with shortened counts
    swwd_sleep_wake #(.P_POR_CYCLES(POR), .P_WDT_RC_CYCLES(50)) dut (
        .i_mclk, .i_rstn, .i_pins, .i_counter_zero, .i_counter_one, .i_exec,
        .i_opcode, .i_int_ack, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
        .o_core_rst_n, .o_cpu_clk_en, .o_sys_tick, .o_osc_run, .o_pc_load,
        .o_pc_value, .o_irq_req, .o_irq_vector, .o_flag_wdt, .o_port_two_direction,
        .o_wdt_armed);
    swwd_pin_model pm (.i_mclk(i_mclk), .o_pins(i_pins));
    // 40 MHz clock
    initial begin
        i_mclk = 1'b0;
        forever #12.5 i_mclk = ~i_mclk;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge i_mclk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_mclk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_mclk);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
        @(posedge i_mclk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_mclk);
        i_rd <= 1'b0;
        #1;
        `CHK(nm, e, o_rdata)
    endtask
    task automatic exec(input logic [7:0] op);
        @(posedge i_mclk);
        i_exec <= 1'b1;
        i_opcode <= op;
        @(posedge i_mclk);
        i_exec <= 1'b0;
    endtask
    // one-cycle pulse: 0 counter zero, 1 counter one, 2 acknowledge
    task automatic pulse(input int w);
        @(posedge i_mclk);
        i_counter_zero <= (w == 0);
        i_counter_one <= (w == 1);
        i_int_ack <= (w == 2);
        @(posedge i_mclk);
        i_counter_zero <= 1'b0;
        i_counter_one <= 1'b0;
        i_int_ack <= 1'b0;
    endtask
    task automatic boot();
        int k;
        int t;
        t = 0;
        for (k = 0; k < 200 && o_core_rst_n !== 1'b1; k++) tick(1);
        `CHK("boot_len", 1'b1, k == POR + swwd_pkg::OSCILLATOR_INPUT_WAIT_CYCLES)
        `CHK("pc_load", 1'b1, o_pc_load)
        `CHK("pc_value", 16'h000c, o_pc_value)
        // eight clocks hold exactly four system ticks
        repeat (8) begin
            tick(1);
            t += o_sys_tick;
        end
        `CHK("sys_tick", 4, t)
    endtask
    task automatic irq_test();
        logic [3:0] pv [4] = '{4'b1101, 4'b1001, 4'b1000, 4'b1010};
        for (int i = 0; i < 6; i++) begin
            wr(8'hfa, 8'h00);
            if (i < 4) pm.drive(pv[i]);
            else pulse(i - 4);
            tick(8);
            rd(8'hfa, 8'h01 << i, "pending");
            `CHK("req_masked", 1'b0, o_irq_req)
            wr(8'hfb, 8'h80 | (8'h01 << i));
            tick(3);
            `CHK("req_on", 1'b1, o_irq_req)
            `CHK("vector", 16'(2 * i), o_irq_vector)
            pulse(2);
            tick(2);
            `CHK("req_off", 1'b0, o_irq_req)
            wr(8'hfb, 8'h00);
        end
        pm.drive(4'b1111);
        // two pending requests: lowest index wins, then highest with order bit
        wr(8'hfa, 8'h21);
        wr(8'hfb, 8'ha1);
        tick(3);
        `CHK("prio_low", 16'h0000, o_irq_vector)
        wr(8'hf9, 8'h01);
        tick(3);
        `CHK("prio_high", 16'h000a, o_irq_vector)
        wr(8'hf9, 8'h00);
        wr(8'hfb, 8'h00);
        wr(8'hfa, 8'h00);
    endtask
    task automatic halt_test();
        int k;
        int seen;
        seen = 0;
        wr(8'hfa, 8'h00);
        wr(8'hfb, 8'h90);
        exec(8'hff);
        exec(swwd_pkg::OP_HALT);
        for (k = 0; k < 8; k++) begin
            tick(1);
            if (o_cpu_clk_en !== 1'b0) seen++;
        end
        `CHK("halt_clk", 0, seen)
        `CHK("halt_osc", 1'b1, o_osc_run)
        pulse(0);
        for (k = 0; k < 20 && o_cpu_clk_en !== 1'b1; k++) tick(1);
        `CHK("halt_exit", 1'b1, o_cpu_clk_en)
        pulse(2);
        wr(8'hfb, 8'h00);
        wr(8'hfa, 8'h00);
    endtask
    task automatic stop_test();
        int k;
        wr(8'hfe, 8'h3c);
        wr(8'hff, 8'h77);
        wr(8'hf6, 8'h85);
        exec(8'hff);
        exec(swwd_pkg::OP_STOP);
        tick(3);
        `CHK("stop_osc", 1'b0, o_osc_run)
        `CHK("stop_clk", 1'b0, o_cpu_clk_en)
        `CHK("stop_tick", 1'b0, o_sys_tick)
        pm.drive(4'b0111);
        for (k = 0; k < 20 && o_pc_load !== 1'b1; k++) tick(1);
        `CHK("wake_load", 1'b1, o_pc_load)
        `CHK("wake_pc", 16'h000c, o_pc_value)
        `CHK("wake_dir", 8'h85, o_port_two_direction)
        pm.drive(4'b1111);
        rd(8'hfe, 8'h00, "scratch");
        rd(8'hff, 8'h00, "stack_low");
    endtask
    task automatic wdt_test();
        int k;
        exec(swwd_pkg::OP_WDT_HALT_KEEP);
        tick(2);
        `CHK("keep_unarmed", 1'b0, o_wdt_armed)
        exec(swwd_pkg::OP_WDT_ARM);
        #1;
        `CHK("flag_wdt", 1'b1, o_flag_wdt)
        tick(1);
        `CHK("armed", 1'b1, o_wdt_armed)
        repeat (3) begin
            tick(30);
            `CHK("refresh", 1'b1, o_core_rst_n)
            exec(swwd_pkg::OP_WDT_ARM);
        end
        exec(swwd_pkg::OP_WDT_HALT_KEEP);
        exec(8'hff);
        exec(swwd_pkg::OP_HALT);
        for (k = 0; k < 80 && o_core_rst_n !== 1'b0; k++) tick(1);
        `CHK("wdt_expire", 1'b0, o_core_rst_n)
        boot();
        `CHK("disarmed", 1'b0, o_wdt_armed)
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        {i_rstn, i_counter_zero, i_counter_one, i_exec, i_int_ack, i_wr, i_rd} = '0;
        {i_opcode, i_addr, i_wdata} = '0;
        repeat (10) @(posedge i_mclk);
        i_rstn <= 1'b1;
        boot();
        `CHK("armed_rst", 1'b0, o_wdt_armed)
        `CHK("dir_rst", 8'hff, o_port_two_direction)
        rd(8'hf6, 8'h00, "dir_wo");
        rd(8'hf9, 8'h00, "prio_wo");
        rd(8'h10, 8'h00, "unmapped");
        rd(8'hfe, 8'h00, "scratch_rst");
        irq_test();
        halt_test();
        stop_test();
        wdt_test();
        wrap_up();
    end
    // hang guard
    initial begin
        repeat (20000) @(posedge i_mclk);
        bad_count++;
        wrap_up();
    end
endmodule // test_swwd_sleep_wake
`default_nettype wire
